// File: core/csc_pkg.sv
// Purpose: Constants shared by the charger supervisor control block
// Assumes: 8-bit register port, 50 MHz clock
// Notes: Ratio figures are scaled by 1000 (milli units of V/V)
package csc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] CSC_REG_CTRL = 3'h0;
    localparam logic [2:0] CSC_REG_MASK = 3'h1;
    localparam logic [2:0] CSC_REG_STATUS = 3'h2;
    localparam logic [2:0] CSC_REG_COUNT = 3'h3;
    localparam logic [2:0] CSC_REG_PEND = 3'h4;

    // Control register fields
    localparam int CSC_CTRL_LOCKOUT = 0;
    localparam int CSC_CTRL_PRIO_USB = 1;
    localparam int CSC_CTRL_CMD_SEC = 2;
    localparam int CSC_CTRL_SUSPEND = 3;
    localparam int CSC_CTRL_RATIO_LSB = 4;

    // Status register fields
    localparam int CSC_ST_COLD = 0;
    localparam int CSC_ST_HOT = 1;
    localparam int CSC_ST_OTG = 2;
    localparam int CSC_ST_WALL_GATE = 3;
    localparam int CSC_ST_USB_GATE = 4;
    localparam int CSC_ST_SEC_SEL = 5;
    localparam int CSC_ST_PAUSE = 6;
    localparam int CSC_ST_OVP = 7;

    // Event bits in pending and mask registers
    localparam int CSC_EV_COLD = 0;
    localparam int CSC_EV_HOT = 1;
    localparam int CSC_EV_OTG = 2;
    localparam int CSC_EV_POWER = 3;
    localparam int CSC_EV_LIMIT = 4;
    localparam int CSC_EV_OVP = 5;
    localparam int CSC_EV_NUM = 6;

    // ------------------------------------------------------------
    // Secondary limit ratio codes
    // ------------------------------------------------------------
    localparam logic [3:0] CSC_RATIO_100MA = 4'h0;
    localparam logic [3:0] CSC_RATIO_500MA = 4'h1;
    localparam logic [3:0] CSC_RATIO_900MA = 4'h5;

    // ------------------------------------------------------------
    // Thermistor digitiser
    // ------------------------------------------------------------
    localparam logic [9:0] CSC_RATIO_LO_MILLI = 10'h0_071;
    localparam logic [9:0] CSC_RATIO_HI_MILLI = 10'h0_37F;
    localparam logic [19:0] CSC_RATIO_SCALE = 20'h0_03E8;
    localparam logic [19:0] CSC_SPAN_MICRO = 20'h0_1812;
    localparam logic [6:0] CSC_CODE_MIN = 7'h00;
    localparam logic [6:0] CSC_CODE_MAX = 7'h7F;
    localparam logic [6:0] CSC_COLD_SET = 7'h66;
    localparam logic [6:0] CSC_COLD_CLR = 7'h62;
    localparam logic [6:0] CSC_HOT_SET = 7'h13;
    localparam logic [6:0] CSC_HOT_CLR = 7'h17;

    // Width of the pin group passed through the synchroniser
    localparam int CSC_SYNC_W = 17;
    // Cable detect idles high; its stages reset high so no false attach follows reset
    localparam logic [CSC_SYNC_W-1:0] CSC_SYNC_RST = 17'h0_0010;

endpackage : csc_pkg

// File: core/csc_sync.sv
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Inputs are levels, not pulses
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module csc_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : csc_sync

// File: core/csc_charger_supervisor_ctrl.sv
// Purpose: Supervisory logic of a battery charger: thermistor, source mux, OVP, OTG, limit select
// Assumes: Analog comparators deliver levels; digitiser delivers ratio in milli V/V with a done level
// Notes: Registers reached over a plain strobe port, read data one cycle later
`timescale 1ns/1ps

// Function
// - Ratio below lower end reads as code zero.
// - Ratio above upper end reads as code 0x7F.
// - Between ends, code rises linearly, one step per fixed ratio span.
// - Cold warning sets at count 102, clears at count 98.
// - Hot fault sets at count 19, clears at count 23.
// - Open-drain active-low interrupt from individually maskable status events.
// - Cable detect low and lockout clear starts reverse power from battery.
// - Reverse power goes only through the USB path, never the wall path.
// - Primary limit pin governs only when primary mode is selected.
// - Secondary pin governs on command or when limit pins are tied.
// - Tied pins at power onset start secondary mode at 100mA.
// - Software selects secondary ratios; 100, 500, 900mA among them.
// - Suspend and reverse power both route limiting to the secondary pin.
// - USB gate drives with USB present and no wall voltage, or with USB priority set; reverse power also drives it.
// - Wall overvoltage forces the wall gate low.
// - USB overvoltage holds the USB gate at zero.
// - Charging pauses while temperature is out of range.
// - Wall wins by default when both present; priority is programmable.
// - A software bit locks out the cable detect from starting reverse power.
module csc_charger_supervisor_ctrl
    import csc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic wall_sense,
    input wire logic wall_sense_ov,
    input wire logic usb_sense,
    input wire logic usb_sense_ov,
    input wire logic host_cable_detect_n,
    input wire logic limit_pins_tied,
    input wire logic conv_done,
    input wire logic [9:0] thermistor_ratio,
    output logic wall_gate_drive,
    output logic usb_gate_drive,
    output logic otg_active,
    output logic secondary_limit_pin_sel,
    output logic primary_limit_pin_sel,
    output logic [3:0] secondary_limit_ratio,
    output logic usb_suspend_limit,
    output logic charge_pause,
    output logic irq_n_out,
    output logic irq_n_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic lockout;
        logic prio_usb;
        logic cmd_sec;
        logic suspend;
        logic [3:0] ratio;
        logic [CSC_EV_NUM-1:0] mask;
        logic [CSC_EV_NUM-1:0] pend;
        logic [6:0] count;
        logic cold;
        logic hot;
        logic conv_d;
        logic power_d;
        logic tied_lock;
        logic wall_gate;
        logic usb_gate;
        logic otg;
        logic sec_sel;
        logic ovp;
        logic pause;
        logic irq_oe;
        logic [7:0] rd_data;
    } csc_state_t;

    csc_state_t q;
    csc_state_t next_q;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [CSC_SYNC_W-1:0] pins_sync;
    logic s_wall;
    logic s_wall_ov;
    logic s_usb;
    logic s_usb_ov;
    logic s_cable_n;
    logic s_tied;
    logic s_conv;
    logic [9:0] s_ratio;

    csc_sync #(.W(CSC_SYNC_W), .RST_VAL(CSC_SYNC_RST)) u_sync
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({thermistor_ratio, conv_done, limit_pins_tied, host_cable_detect_n,
                   usb_sense_ov, usb_sense, wall_sense_ov, wall_sense}),
        .sync_out(pins_sync)
    );

    assign s_wall = pins_sync[0];
    assign s_wall_ov = pins_sync[1];
    assign s_usb = pins_sync[2];
    assign s_usb_ov = pins_sync[3];
    assign s_cable_n = pins_sync[4];
    assign s_tied = pins_sync[5];
    assign s_conv = pins_sync[6];
    assign s_ratio = pins_sync[16:7];

    // ------------------------------------------------------------
    // Digitiser transfer
    // ------------------------------------------------------------
    // Division by a constant; a slow path but only one conversion per frame
    function automatic logic [6:0] csc_ratio_to_code(input logic [9:0] r);
        logic [19:0] num;
        logic [19:0] quo;
        num = 20'h0_0000;
        quo = 20'h0_0000;
        if (r < CSC_RATIO_LO_MILLI)
        begin
            csc_ratio_to_code = CSC_CODE_MIN;
        end
        else if (r > CSC_RATIO_HI_MILLI)
        begin
            csc_ratio_to_code = CSC_CODE_MAX;
        end
        else
        begin
            num = 20'(r - CSC_RATIO_LO_MILLI) * CSC_RATIO_SCALE;
            quo = num / CSC_SPAN_MICRO;
            csc_ratio_to_code = quo[6:0];
        end
    endfunction : csc_ratio_to_code

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic conv_edge;
    logic power_now;
    logic otg_now;
    logic wall_ok;
    logic usb_ok;
    logic [6:0] code_now;
    logic [CSC_EV_NUM-1:0] events;
    logic [CSC_EV_NUM-1:0] clr;

    always_comb
    begin
        next_q = q;
        conv_edge = s_conv & ~q.conv_d;
        power_now = s_wall | s_usb;
        wall_ok = s_wall & ~s_wall_ov;
        usb_ok = s_usb & ~s_usb_ov;
        code_now = csc_ratio_to_code(s_ratio);
        clr = '0;

        next_q.conv_d = s_conv;
        next_q.power_d = power_now;

        // Register writes
        if (reg_wr)
        begin
            if (reg_addr == CSC_REG_CTRL)
            begin
                next_q.lockout = reg_wdata[CSC_CTRL_LOCKOUT];
                next_q.prio_usb = reg_wdata[CSC_CTRL_PRIO_USB];
                next_q.cmd_sec = reg_wdata[CSC_CTRL_CMD_SEC];
                next_q.suspend = reg_wdata[CSC_CTRL_SUSPEND];
                next_q.ratio = reg_wdata[CSC_CTRL_RATIO_LSB +: 4];
            end
            else if (reg_addr == CSC_REG_MASK)
            begin
                next_q.mask = reg_wdata[CSC_EV_NUM-1:0];
            end
            else if (reg_addr == CSC_REG_PEND)
            begin
                clr = reg_wdata[CSC_EV_NUM-1:0];
            end
        end

        // Tie strap caught at the onset of input power
        if (power_now && !q.power_d)
        begin
            next_q.tied_lock = s_tied;
            if (s_tied)
            begin
                next_q.ratio = CSC_RATIO_100MA;
            end
        end
        else if (!power_now)
        begin
            next_q.tied_lock = 1'b0;
        end

        // Thermistor sample and hysteresis per conversion
        if (conv_edge)
        begin
            next_q.count = code_now;
            if (code_now >= CSC_COLD_SET)
            begin
                next_q.cold = 1'b1;
            end
            else if (code_now <= CSC_COLD_CLR)
            begin
                next_q.cold = 1'b0;
            end
            if (code_now <= CSC_HOT_SET)
            begin
                next_q.hot = 1'b1;
            end
            else if (code_now >= CSC_HOT_CLR)
            begin
                next_q.hot = 1'b0;
            end
        end
        next_q.pause = next_q.cold | next_q.hot;

        // Reverse power and source mux
        otg_now = ~s_cable_n & ~q.lockout;
        next_q.otg = otg_now;
        next_q.wall_gate = wall_ok & ~otg_now & (~q.prio_usb | ~usb_ok);
        if (otg_now)
        begin
            next_q.usb_gate = ~s_usb_ov;
        end
        else if (q.prio_usb)
        begin
            next_q.usb_gate = usb_ok;
        end
        else
        begin
            next_q.usb_gate = usb_ok & ~s_wall;
        end
        next_q.ovp = s_wall_ov | s_usb_ov;
        next_q.sec_sel = q.cmd_sec | q.tied_lock | q.suspend | otg_now;

        // Sticky events; a new event wins over a clear in the same cycle
        events = '0;
        events[CSC_EV_COLD] = next_q.cold ^ q.cold;
        events[CSC_EV_HOT] = next_q.hot ^ q.hot;
        events[CSC_EV_OTG] = next_q.otg ^ q.otg;
        events[CSC_EV_POWER] = (next_q.wall_gate ^ q.wall_gate) | (next_q.usb_gate ^ q.usb_gate);
        events[CSC_EV_LIMIT] = next_q.sec_sel ^ q.sec_sel;
        events[CSC_EV_OVP] = next_q.ovp ^ q.ovp;
        next_q.pend = (q.pend & ~clr) | events;
        next_q.irq_oe = |(next_q.pend & next_q.mask);

        // Read data, one cycle after the strobe
        next_q.rd_data = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == CSC_REG_CTRL)
            begin
                next_q.rd_data = {q.ratio, q.suspend, q.cmd_sec, q.prio_usb, q.lockout};
            end
            else if (reg_addr == CSC_REG_MASK)
            begin
                next_q.rd_data = {2'b00, q.mask};
            end
            else if (reg_addr == CSC_REG_STATUS)
            begin
                next_q.rd_data = {q.ovp, q.pause, q.sec_sel, q.usb_gate, q.wall_gate,
                                  q.otg, q.hot, q.cold};
            end
            else if (reg_addr == CSC_REG_COUNT)
            begin
                next_q.rd_data = {1'b0, q.count};
            end
            else if (reg_addr == CSC_REG_PEND)
            begin
                next_q.rd_data = {2'b00, q.pend};
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = q.rd_data;
    assign wall_gate_drive = q.wall_gate;
    assign usb_gate_drive = q.usb_gate;
    assign otg_active = q.otg;
    assign secondary_limit_pin_sel = q.sec_sel;
    // Primary mode is the complement; one flop drives both pins, through an inverter on this one
    assign primary_limit_pin_sel = ~q.sec_sel;
    assign secondary_limit_ratio = q.ratio;
    assign usb_suspend_limit = q.suspend;
    assign charge_pause = q.pause;
    // Open drain: only ever pulls low
    assign irq_n_out = 1'b0;
    assign irq_n_oe = q.irq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking csc_cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    chk_sat_low_code: assert property (conv_edge && s_ratio < CSC_RATIO_LO_MILLI |=> q.count == CSC_CODE_MIN)
        else $error("thermistor code not zero below range");
    chk_sat_high_code: assert property (conv_edge && s_ratio > CSC_RATIO_HI_MILLI |=> q.count == CSC_CODE_MAX)
        else $error("thermistor code not saturated above range");
    chk_linear_step: assert property (conv_edge && s_ratio >= CSC_RATIO_LO_MILLI && s_ratio <= CSC_RATIO_HI_MILLI
        |=> (20'(q.count) * CSC_SPAN_MICRO <= 20'($past(s_ratio) - CSC_RATIO_LO_MILLI) * CSC_RATIO_SCALE)
            && (20'($past(s_ratio) - CSC_RATIO_LO_MILLI) * CSC_RATIO_SCALE
                < 20'(q.count + 7'h01) * CSC_SPAN_MICRO))
        else $error("thermistor code off linear transfer");
    chk_cold_hyst: assert property ((q.count >= CSC_COLD_SET |-> q.cold) and (q.count <= CSC_COLD_CLR |-> !q.cold))
        else $error("cold warning disagrees with count");
    chk_hot_hyst: assert property (($past(conv_edge) && q.count <= CSC_HOT_SET |-> q.hot)
        and (q.count >= CSC_HOT_CLR |-> !q.hot))
        else $error("hot fault disagrees with count");
    chk_irq_masked: assert property (irq_n_oe == |(q.pend & q.mask))
        else $error("interrupt pin not the masked pending set");
    chk_otg_start: assert property (!s_cable_n && !q.lockout |=> otg_active)
        else $error("reverse power did not start");
    chk_otg_lockout: assert property (q.lockout && $stable(q.lockout) |=> !otg_active)
        else $error("reverse power started despite lockout");
    chk_otg_path: assert property (otg_active |-> !wall_gate_drive)
        else $error("reverse power through wall path");
    chk_wall_ovp: assert property (s_wall_ov |=> !wall_gate_drive)
        else $error("wall gate driven in overvoltage");
    chk_usb_ovp: assert property (s_usb_ov |=> !usb_gate_drive)
        else $error("usb gate driven in overvoltage");
    chk_usb_gate: assert property (usb_gate_drive && !$past(q.prio_usb) && !otg_active
        |-> $past(s_usb) && !$past(s_wall))
        else $error("usb gate driven with wall present");
    chk_wall_prio: assert property (s_wall && !s_wall_ov && s_usb && !q.prio_usb && !otg_now
        |=> wall_gate_drive && !usb_gate_drive)
        else $error("wall input not preferred");
    chk_sec_select: assert property (q.cmd_sec || q.suspend |=> secondary_limit_pin_sel)
        else $error("secondary limit pin not selected");
    chk_tie_onset: assert property (power_now && !q.power_d && s_tied
        |=> ##1 secondary_limit_pin_sel && secondary_limit_ratio == CSC_RATIO_100MA)
        else $error("tied pins did not start in 100mA secondary mode");
    chk_pause_range: assert property (charge_pause == (q.cold || q.hot))
        else $error("charge pause not following temperature");

    cov_otg_session: cover property (!otg_active ##1 otg_active ##[1:20] !otg_active);
    cov_cold_cycle: cover property (q.cold ##[1:200] !q.cold);
    cov_hot_fault: cover property (!q.hot ##1 q.hot);
    cov_irq_clear: cover property (irq_n_oe ##1 reg_wr && reg_addr == CSC_REG_PEND ##1 !irq_n_oe);

endmodule : csc_charger_supervisor_ctrl

// File: tb/csc_adc_model.sv
// Purpose: Behavioural model of the thermistor digitiser feeding the block
// Assumes: Runs on the bench clock; one conversion at a time
// Notes: Ratio line is scrambled once its hold after a conversion has run out
`timescale 1ns/1ps
module csc_adc_model
(
    input wire logic clock,
    output logic conv_done,
    output logic [9:0] thermistor_ratio
);
    initial
    begin
        conv_done = 1'b0;
        thermistor_ratio = 10'h000;
    end

    // ------------------------------------------------------------
    // One conversion; slow stretches the setup before the done edge
    // ------------------------------------------------------------
    task automatic convert(input logic [9:0] ratio, input int slow);
        @(posedge clock);
        thermistor_ratio <= ratio;
        repeat (1 + slow) @(posedge clock);
        conv_done <= 1'b1;
        // Held well past the three clocks the block needs
        repeat (8) @(posedge clock);
        conv_done <= 1'b0;
        @(posedge clock);
        // Stale value must not look valid
        thermistor_ratio <= ~ratio;
    endtask : convert
endmodule : csc_adc_model

// File: tb/csc_charger_supervisor_ctrl_tb.sv
// Purpose: Self-checking bench for the charger supervisor control block
// Assumes: Register reads answer in the following cycle only
// Notes: Reads are queued with expected value and mask, compared by a monitor
`timescale 1ns/1ps
module csc_charger_supervisor_ctrl_tb;
    import csc_pkg::*;

    logic clock, sys_rst, reg_wr, reg_rd;
    logic rd_q = 1'b0;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic wall_sense, wall_sense_ov, usb_sense, usb_sense_ov, host_cable_detect_n;
    logic limit_pins_tied, conv_done, wall_gate_drive, usb_gate_drive, otg_active;
    logic secondary_limit_pin_sel, primary_limit_pin_sel, usb_suspend_limit;
    logic charge_pause, irq_n_out, irq_n_oe, cold_m, hot_m;
    logic [9:0] thermistor_ratio;
    logic [3:0] secondary_limit_ratio;
    logic [15:0] exp_q[$];
    logic [31:0] lfsr_state = 32'h0000_4831;
    int fails = 0;
    int num_checks = 0;

    csc_charger_supervisor_ctrl i_csc_charger_supervisor_ctrl (.clock, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .wall_sense, .wall_sense_ov, .usb_sense, .usb_sense_ov,
        .host_cable_detect_n, .limit_pins_tied, .conv_done, .thermistor_ratio, .wall_gate_drive,
        .usb_gate_drive, .otg_active, .secondary_limit_pin_sel, .primary_limit_pin_sel,
        .secondary_limit_ratio, .usb_suspend_limit, .charge_pause, .irq_n_out, .irq_n_oe);
    csc_adc_model i_csc_adc_model (.clock, .conv_done, .thermistor_ratio);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic chk_reg(input logic [7:0] got, input logic [15:0] e);
        chk_pin(got & e[15:8], e[7:0] & e[15:8]);
    endtask : chk_reg

    task automatic conclude();
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Read data stands only in the cycle after the strobe
    always @(posedge clock)
    begin
        if (rd_q)
        begin
            if (exp_q.size() == 0)
            begin
                fails++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, reg_rdata, 8'h00);
            end
            else
                chk_reg(reg_rdata, exp_q.pop_front());
        end
        rd_q <= reg_rd;
    end

    // ------------------------------------------------------------
    // Register port and stimulus helpers
    // ------------------------------------------------------------
    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
        exp_q.push_back({mask, exp});
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : reg_read

    function automatic logic [31:0] lfsr_next();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state;
    endfunction : lfsr_next

    function automatic logic [6:0] code_of(input logic [9:0] r);
        int v;
        v = (int'(r) - 113) * 1000 / 6162;
        if (r < 10'h071)
            v = 0;
        if (r > 10'h37F || v > 127)
            v = 127;
        return v[6:0];
    endfunction : code_of

    task automatic therm(input logic [9:0] r, input int slow);
        logic [6:0] c;
        c = code_of(r);
        if (c >= 7'h66) cold_m = 1'b1; else if (c <= 7'h62) cold_m = 1'b0;
        if (c <= 7'h13) hot_m = 1'b1; else if (c >= 7'h17) hot_m = 1'b0;
        i_csc_adc_model.convert(r, slow);
        reg_read(CSC_REG_COUNT, {1'b0, c}, 8'h7F);
        reg_read(CSC_REG_STATUS, {1'b0, cold_m | hot_m, 4'h0, hot_m, cold_m}, 8'h43);
        chk_pin({7'h00, charge_pause}, {7'h00, cold_m | hot_m});
    endtask : therm

    // ------------------------------------------------------------
    // Tables: ratios, then {ctrl, wall, wall_ov, usb, usb_ov, cable_n}
    // ------------------------------------------------------------
    // Range ends and both hysteresis edges
    logic [9:0] ratio_tab [14] = '{10'h0F0, 10'h0E6, 10'h0F0, 10'h0FF, 10'h2E6, 10'h2D5, 10'h2D0,
        10'h2E6, 10'h384, 10'h070, 10'h071, 10'h37F, 10'h380, 10'h3FF};
    // Wall only, wall ov, usb, usb ov, both, usb prio
    // Cable, lockout, cable with usb ov, 500mA, suspend 900mA, 100mA
    logic [15:0] src_tab [12] = '{16'h0011, 16'h0019, 16'h0005, 16'h0007, 16'h0015, 16'h0055,
        16'h0000, 16'h0020, 16'h0002, 16'h0291, 16'h0B11, 16'h0091};

    initial
    begin
        logic [15:0] e;
        logic [31:0] rv;
        logic otg, uok, wg, ug, sec;
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {wall_sense, wall_sense_ov, usb_sense, usb_sense_ov, limit_pins_tied} = '0;
        host_cable_detect_n = 1'b1;
        {cold_m, hot_m} = 2'b00;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clock);
        // ------------------------------------------------------------
        // Reset values, read-only and unmapped places
        // ------------------------------------------------------------
        chk_pin({7'h00, primary_limit_pin_sel}, 8'h01);
        reg_read(CSC_REG_CTRL, 8'h00, 8'hFF);
        reg_read(CSC_REG_MASK, 8'h00, 8'h3F);
        reg_write(CSC_REG_COUNT, 8'h55);
        reg_write(3'h5, 8'hFF);
        reg_read(CSC_REG_COUNT, 8'h00, 8'hFF);
        for (int a = 5; a < 8; a++)
            reg_read(a[2:0], 8'h00, 8'hFF);
        // ------------------------------------------------------------
        // Interrupt raise, clear and mask
        // ------------------------------------------------------------
        reg_write(CSC_REG_PEND, 8'h3F);
        reg_write(CSC_REG_MASK, 8'h02);
        therm(10'h032, 0);
        chk_pin({7'h00, irq_n_oe}, 8'h01);
        chk_pin({7'h00, irq_n_out}, 8'h00);
        reg_read(CSC_REG_PEND, 8'h02, 8'h02);
        reg_write(CSC_REG_PEND, 8'h3F);
        repeat (2) @(posedge clock);
        chk_pin({7'h00, irq_n_oe}, 8'h00);
        reg_write(CSC_REG_MASK, 8'h00);
        therm(10'h0FF, 1);
        chk_pin({7'h00, irq_n_oe}, 8'h00);
        // ------------------------------------------------------------
        // Thermistor table, then random ratios
        // ------------------------------------------------------------
        foreach (ratio_tab[i])
            therm(ratio_tab[i], i % 2);
        for (int i = 0; i < 6; i++)
        begin
            rv = lfsr_next();
            therm(rv[9:0], i % 2);
        end
        // ------------------------------------------------------------
        // Source selection, reverse power and limit pin
        // ------------------------------------------------------------
        foreach (src_tab[i])
        begin
            e = src_tab[i];
            reg_write(CSC_REG_CTRL, e[12:5]);
            @(posedge clock);
            {wall_sense, wall_sense_ov, usb_sense, usb_sense_ov, host_cable_detect_n} <= e[4:0];
            repeat (5) @(posedge clock);
            otg = !e[0] && !e[5];
            uok = e[2] && !e[1];
            wg = e[4] && !e[3] && !otg && !(e[6] && uok);
            ug = otg ? !e[1] : (uok && (e[6] || !e[4]));
            sec = e[7] || e[8] || otg;
            chk_pin({7'h00, wall_gate_drive}, {7'h00, wg});
            chk_pin({7'h00, usb_gate_drive}, {7'h00, ug});
            chk_pin({7'h00, otg_active}, {7'h00, otg});
            chk_pin({7'h00, secondary_limit_pin_sel}, {7'h00, sec});
            chk_pin({7'h00, primary_limit_pin_sel}, {7'h00, !sec});
            chk_pin({7'h00, usb_suspend_limit}, {7'h00, e[8]});
            chk_pin({4'h0, secondary_limit_ratio}, {4'h0, e[12:9]});
            reg_read(CSC_REG_STATUS, {e[3] | e[1], cold_m | hot_m, sec, ug, wg, otg, hot_m, cold_m}, 8'hFF);
            reg_read(CSC_REG_CTRL, e[12:5], 8'hFF);
        end
        // ------------------------------------------------------------
        // Tied limit pins at power onset
        // ------------------------------------------------------------
        reg_write(CSC_REG_CTRL, 8'h50);
        @(posedge clock);
        {wall_sense, wall_sense_ov, usb_sense, usb_sense_ov, host_cable_detect_n} <= 5'h01;
        limit_pins_tied <= 1'b1;
        repeat (5) @(posedge clock);
        wall_sense <= 1'b1;
        repeat (6) @(posedge clock);
        chk_pin({7'h00, secondary_limit_pin_sel}, 8'h01);
        chk_pin({4'h0, secondary_limit_ratio}, {4'h0, CSC_RATIO_100MA});
        chk_pin({7'h00, primary_limit_pin_sel}, 8'h00);
        repeat (3) @(posedge clock);
        conclude();
    end

    // Whole run is under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        conclude();
    end
endmodule : csc_charger_supervisor_ctrl_tb
